// [rtl/gpio_port_pkg.sv]
// Purpose: Shared constants and state type for the eight-pin I/O port
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register
// Notes: Only the low byte of each register carries data; upper bits read zero
package gpio_port_pkg;
    localparam int PIN_COUNT = 8;
    // Register byte offsets
    localparam logic [7:0] OFFSET_DATA = 8'h00;
    localparam logic [7:0] OFFSET_DIRECTION = 8'h04;
    localparam logic [7:0] OFFSET_OPTION = 8'h08;
    localparam logic [7:0] OFFSET_SENSITIVITY = 8'h0c;
    // Sensitivity field position and width
    localparam int SENS_LSB = 0;
    localparam int SENS_WIDTH = 2;
    // Reset values
    localparam logic [7:0] RESET_DATA = 8'h00;
    localparam logic [7:0] RESET_DIRECTION = 8'h00;
    localparam logic [7:0] RESET_OPTION = 8'h00;
    localparam logic [1:0] RESET_SENSITIVITY = 2'h0;
    localparam logic RESET_COMBINED = 1'b1;
    // Sensitivity encodings of the combined request line
    localparam logic [1:0] SENS_FALL_LOW = 2'h0;
    localparam logic [1:0] SENS_RISE = 2'h1;
    localparam logic [1:0] SENS_FALL = 2'h2;
    localparam logic [1:0] SENS_BOTH = 2'h3;

    typedef enum logic [2:0] {
        REG_DATA,
        REG_DIRECTION,
        REG_OPTION,
        REG_SENSITIVITY,
        REG_NONE
    } reg_sel_type;

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] direction;
        logic [7:0] option;
        logic [1:0] sensitivity;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] sync_first;
        logic [7:0] sync_second;
        logic combined_prev;
        logic request;
    } state_type;
endpackage

// [rtl/gpio_port.sv]
// Purpose: Eight-pin bidirectional I/O port with external interrupt request
// Assumes: Single 100 MHz clock, synchronous active-high reset, Wishbone slave
// Notes: Pins are split into in, out and enable; the pad wiring resolves them
// What this block does
// - Eight pins, bit X controls pin X
// - Input mode reads back the pin level
// - Writes in input mode only update latch
// - Option bit picks floating or pull-up input
// - Output mode drives latch value onto pin
// - Option picks push-pull or open-drain output
// - Output mode reads pin, not latch
// - Interrupt pins raise requests, programmable sensitivity
// - Enabled pins ANDed, low pin masks others
// - Disabled pin forces edge detector input high
// - Request latch clears on vector fetch
// - Peripheral drive overrides direction and option; a claim only blocks the interrupt
// - Peripheral-driven pin becomes output automatically
// - Input mode with driving peripheral reads its output
// - Output mode feeds latch to peripheral input
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ns
module gpio_port
    import gpio_port_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pads
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pull_up_enable,
    // On-chip peripheral alternate functions
    input wire logic [7:0] alt_claim,
    input wire logic [7:0] alt_drive,
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_open_drain,
    output logic [7:0] alt_in,
    // External interrupt vector
    input wire logic vector_fetch,
    output logic ext_irq_request
);
    state_type state;
    state_type next_state;
    logic [7:0] drive_value;
    logic [7:0] drive_open_drain;
    logic [7:0] drive_active;
    logic [7:0] irq_enabled;
    logic [7:0] detector_input;
    logic [7:0] pin_view;
    logic combined;
    logic edge_fall;
    logic edge_rise;
    logic event_hit;
    logic bus_request;
    reg_sel_type access_sel;

    // Address decode, shared by the read mux and the write path
    function automatic reg_sel_type decode_reg(input logic [7:0] adr);
        reg_sel_type sel;
        sel = REG_NONE;
        if (adr[7:2] == OFFSET_DATA[7:2]) begin
            sel = REG_DATA;
        end else if (adr[7:2] == OFFSET_DIRECTION[7:2]) begin
            sel = REG_DIRECTION;
        end else if (adr[7:2] == OFFSET_OPTION[7:2]) begin
            sel = REG_OPTION;
        end else if (adr[7:2] == OFFSET_SENSITIVITY[7:2]) begin
            sel = REG_SENSITIVITY;
        end
        return sel;
    endfunction

    // Per-pin driver, pull-up and interrupt gating
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        always_comb begin
            // A driving peripheral wins over software programming
            drive_active[i] = alt_drive[i] | state.direction[i];
            drive_value[i] = alt_drive[i] ? alt_out[i] : state.latch[i];
            drive_open_drain[i] = alt_drive[i] ? alt_open_drain[i] : state.option[i];
            // Open-drain only ever pulls low; a one leaves the pin floating
            pin_oe[i] = drive_active[i] & (~drive_value[i] | ~drive_open_drain[i]);
            pin_out[i] = drive_value[i] & ~drive_open_drain[i];
            // Pull-up only on an undriven input with its option set
            pull_up_enable[i] = ~drive_active[i] & state.option[i];
            // Interrupt input needs input mode, option set and no peripheral claim
            irq_enabled[i] = ~state.direction[i] & state.option[i] & ~alt_claim[i];
            // A disabled pin presents a one so it cannot mask the others
            detector_input[i] = irq_enabled[i] ? state.sync_second[i] : 1'b1;
            // Input mode with a driving peripheral reads its output
            pin_view[i] = (~state.direction[i] & alt_drive[i]) ? alt_out[i]
                : state.sync_second[i];
            // Output mode hands the latch to a receiving peripheral
            alt_in[i] = state.direction[i] ? state.latch[i] : state.sync_second[i];
        end
    end

    // Request combining and edge sensing
    always_comb begin
        combined = &detector_input;
        edge_fall = state.combined_prev & ~combined;
        edge_rise = ~state.combined_prev & combined;
        unique case (state.sensitivity)
            SENS_FALL_LOW: event_hit = ~combined;
            SENS_RISE: event_hit = edge_rise;
            SENS_FALL: event_hit = edge_fall;
            SENS_BOTH: event_hit = edge_fall | edge_rise;
        endcase
    end

    // Bus request seen this cycle, answered one edge later
    assign bus_request = wb_cyc_i & wb_stb_i & ~state.ack;
    assign access_sel = decode_reg(wb_adr_i);

    // Next-state logic for registers, synchronisers and the request latch
    always_comb begin
        next_state = state;
        next_state.ack = bus_request;
        // The first stage feeds only the second stage
        next_state.sync_first = pin_in;
        next_state.sync_second = state.sync_first;
        next_state.combined_prev = combined;
        next_state.rdata = 32'h0000_0000;
        if (bus_request && !wb_we_i) begin
            unique case (access_sel)
                REG_DATA: next_state.rdata[7:0] = pin_view;
                REG_DIRECTION: next_state.rdata[7:0] = state.direction;
                REG_OPTION: next_state.rdata[7:0] = state.option;
                REG_SENSITIVITY: begin
                    next_state.rdata[SENS_LSB +: SENS_WIDTH] = state.sensitivity;
                end
                REG_NONE: next_state.rdata = 32'h0000_0000;
            endcase
        end
        // Writes land with the ack; unmapped addresses are acked and dropped
        if (bus_request && wb_we_i && wb_sel_i[0]) begin
            unique case (access_sel)
                REG_DATA: next_state.latch = wb_dat_i[7:0];
                REG_DIRECTION: next_state.direction = wb_dat_i[7:0];
                REG_OPTION: next_state.option = wb_dat_i[7:0];
                REG_SENSITIVITY: begin
                    next_state.sensitivity = wb_dat_i[SENS_LSB +: SENS_WIDTH];
                end
                REG_NONE: next_state.latch = state.latch;
            endcase
        end
        // Fetch clears the latch, but a new event in that cycle still wins
        if (vector_fetch) begin
            next_state.request = 1'b0;
        end
        if (event_hit) begin
            next_state.request = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            state.latch <= RESET_DATA;
            state.direction <= RESET_DIRECTION;
            state.option <= RESET_OPTION;
            state.sensitivity <= RESET_SENSITIVITY;
            state.ack <= 1'b0;
            state.rdata <= 32'h0000_0000;
            state.sync_first <= 8'h00;
            state.sync_second <= 8'h00;
            state.combined_prev <= RESET_COMBINED;
            state.request <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs from flip-flops
    assign wb_ack_o = state.ack;
    assign wb_dat_o = state.rdata;
    assign ext_irq_request = state.request;

    // Checks on the bus handshake
    property ack_one_cycle;
        @(posedge clk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    ack_pulse_a: assert property (ack_one_cycle) else $error("ack held longer than one cycle");

    property ack_follows_request;
        @(posedge clk) disable iff (reset)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    ack_latency_a: assert property (ack_follows_request) else $error("ack not one cycle after request");

    // Checks on register effects
    property direction_write;
        @(posedge clk) disable iff (reset)
        (bus_request && wb_we_i && wb_sel_i[0] && access_sel == REG_DIRECTION)
            |=> state.direction == $past(wb_dat_i[7:0]);
    endproperty
    direction_store_a: assert property (direction_write) else $error("direction not stored");

    property data_read_view;
        @(posedge clk) disable iff (reset)
        (bus_request && !wb_we_i && access_sel == REG_DATA)
            |=> wb_ack_o && wb_dat_o == {24'h000000, $past(pin_view)};
    endproperty
    data_read_a: assert property (data_read_view) else $error("data read not pin view");

    property input_write_no_drive;
        @(posedge clk) disable iff (reset)
        (pin_oe & ~(state.direction | alt_drive)) == 8'h00;
    endproperty
    input_undriven_a: assert property (input_write_no_drive) else $error("input pin driven");

    // Checks on pin drive
    property push_pull_drive;
        @(posedge clk) disable iff (reset)
        (state.direction[0] && !state.option[0] && !alt_drive[0])
            |-> pin_oe[0] && pin_out[0] == state.latch[0];
    endproperty
    push_pull_a: assert property (push_pull_drive) else $error("push-pull pin 0 wrong");

    property open_drain_float;
        @(posedge clk) disable iff (reset)
        (state.direction[0] && state.option[0] && !alt_drive[0] && state.latch[0])
            |-> !pin_oe[0];
    endproperty
    open_drain_a: assert property (open_drain_float) else $error("open-drain one driven");

    property peripheral_drive;
        @(posedge clk) disable iff (reset)
        (alt_drive[0] && !alt_open_drain[0]) |-> pin_oe[0] && pin_out[0] == alt_out[0];
    endproperty
    alt_override_a: assert property (peripheral_drive) else $error("peripheral not driving");

    property latch_to_peripheral;
        @(posedge clk) disable iff (reset)
        state.direction[0] |-> alt_in[0] == state.latch[0];
    endproperty
    alt_input_a: assert property (latch_to_peripheral) else $error("peripheral input not latch");

    // Checks on the request latch, pin masking and reset
    property falling_edge_request;
        @(posedge clk) disable iff (reset)
        (state.sensitivity == SENS_FALL && state.combined_prev && !combined)
            |=> ext_irq_request;
    endproperty
    edge_request_a: assert property (falling_edge_request) else $error("falling edge missed");

    property fetch_clears;
        @(posedge clk) disable iff (reset)
        (vector_fetch && !event_hit) |=> !ext_irq_request;
    endproperty
    fetch_clear_a: assert property (fetch_clears) else $error("request not cleared");

    property masked_by_low;
        @(posedge clk) disable iff (reset)
        (irq_enabled[0] && !state.sync_second[0]) |-> !combined;
    endproperty
    low_masks_a: assert property (masked_by_low) else $error("low pin did not mask");

    property disabled_high;
        @(posedge clk) disable iff (reset)
        !irq_enabled[0] |-> detector_input[0];
    endproperty
    disabled_high_a: assert property (disabled_high) else $error("disabled pin not high");

    property reset_config;
        @(posedge clk)
        reset |=> state.direction == 8'h00 && state.option == 8'h00 && pin_oe == 8'h00;
    endproperty
    reset_clear_a: assert property (reset_config) else $error("config not cleared");

    // Further checks on pull-ups, latch writes, read-back and drive
    property pull_up_input;
        @(posedge clk) disable iff (reset)
        pull_up_enable == (~state.direction & ~alt_drive & state.option);
    endproperty
    pull_up_a: assert property (pull_up_input) else $error("pull-up wrong");

    property latch_write;
        @(posedge clk) disable iff (reset)
        (bus_request && wb_we_i && wb_sel_i[0] && access_sel == REG_DATA)
            |=> state.latch == $past(wb_dat_i[7:0]);
    endproperty
    latch_store_a: assert property (latch_write) else $error("latch not stored");

    property output_pin_read;
        @(posedge clk) disable iff (reset)
        (bus_request && !wb_we_i && access_sel == REG_DATA
            && state.direction[0] && !alt_drive[0])
            |=> wb_dat_o[0] == $past(state.sync_second[0]);
    endproperty
    output_read_a: assert property (output_pin_read) else $error("output read not pin");

    property alt_output_read;
        @(posedge clk) disable iff (reset)
        (bus_request && !wb_we_i && access_sel == REG_DATA
            && !state.direction[0] && alt_drive[0])
            |=> wb_dat_o[0] == $past(alt_out[0]);
    endproperty
    alt_read_a: assert property (alt_output_read) else $error("read not peripheral output");

    property open_drain_low;
        @(posedge clk) disable iff (reset)
        (state.direction[0] && state.option[0] && !alt_drive[0] && !state.latch[0])
            |-> pin_oe[0] && !pin_out[0];
    endproperty
    drain_low_a: assert property (open_drain_low) else $error("open-drain zero not driven");

    property alt_drive_low;
        @(posedge clk) disable iff (reset)
        (alt_drive[0] && !alt_out[0]) |-> pin_oe[0] && !pin_out[0];
    endproperty
    alt_drive_low_a: assert property (alt_drive_low) else $error("peripheral low lost");

    // Further checks on the request latch
    property rising_edge_request;
        @(posedge clk) disable iff (reset)
        (state.sensitivity == SENS_RISE && !state.combined_prev && combined)
            |=> ext_irq_request;
    endproperty
    rise_request_a: assert property (rising_edge_request) else $error("rising edge missed");

    property fetch_with_event;
        @(posedge clk) disable iff (reset)
        (vector_fetch && event_hit) |=> ext_irq_request;
    endproperty
    set_wins_a: assert property (fetch_with_event) else $error("event lost to fetch");

    property request_hold;
        @(posedge clk) disable iff (reset)
        (!event_hit && !vector_fetch) |=> ext_irq_request == $past(ext_irq_request);
    endproperty
    request_hold_a: assert property (request_hold) else $error("request changed alone");

    // Main scenarios
    cover property (@(posedge clk) disable iff (reset)
        bus_request && wb_we_i && access_sel == REG_DIRECTION);
    cover property (@(posedge clk) disable iff (reset) $rose(ext_irq_request));
    cover property (@(posedge clk) disable iff (reset) ext_irq_request ##1 vector_fetch);
    cover property (@(posedge clk) disable iff (reset)
        state.direction[0] && state.option[0] && state.latch[0] && !state.sync_second[0]);
endmodule

// [testbench/pad_board.sv]
// Purpose: Board and pad model that resolves each port pin level
// Assumes: The board either drives a pin or leaves it to the port
// Notes: A pin with no driver and no pull-up drifts every cycle
`timescale 1ns/1ns
module pad_board (
    // Clock
    input wire logic clk,
    // Port side of the pads
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up_enable,
    // Board side
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] level
);
    logic [7:0] drift = 8'h00;
    // Floating pins keep changing so a stale value never reads as real
    always @(posedge clk) begin
        drift <= ~drift;
    end
    // Port driver wins, then board drive, then the pull-up
    always_comb begin
        level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
            | (~pin_oe & ~ext_en & (pull_up_enable | drift));
    end
endmodule

// [testbench/bidir_io_port_with_ext_interrupts_bench.sv]
// Purpose: Self-checking bench for the eight-pin port
// Assumes: Board drives every pin the port leaves undriven, except in the pull-up test
// Notes: Random pin setups plus hand-made interrupt corner cases
`timescale 1ns/1ns
module bidir_io_port_with_ext_interrupts_bench;
    import gpio_port_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fetch = 1'b0, ack, irq;
    logic [7:0] adr = 8'h00, alt_claim = 8'h00, alt_drive = 8'h00;
    logic [7:0] alt_out = 8'h00, alt_od = 8'h00, ext_val = 8'h5a, ext_en = 8'hff;
    logic [7:0] level, pout, poe, pull, alt_in, l, dir, opt, oe, lv, rv;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, rd, seed = 32'd42127;
    int n_fail = 0;
    int samples_checked = 0;

    gpio_port dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .pin_in(level), .pin_out(pout),
        .pin_oe(poe), .pull_up_enable(pull), .alt_claim(alt_claim),
        .alt_drive(alt_drive), .alt_out(alt_out), .alt_open_drain(alt_od),
        .alt_in(alt_in), .vector_fetch(fetch), .ext_irq_request(irq));
    pad_board board (.clk(clk), .pin_out(pout), .pin_oe(poe),
        .pull_up_enable(pull), .ext_en(ext_en), .ext_val(ext_val), .level(level));

    // Clock
    always #5 clk = ~clk;

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // Expected pad enable: a driving peripheral first, then the output latch
    function automatic logic [7:0] exp_oe(input logic [7:0] d, input logic [7:0] o,
        input logic [7:0] lt);
        return (alt_drive & ~(alt_od & alt_out)) | (~alt_drive & d & ~(o & lt));
    endfunction

    // Expected pad level: the port where it drives, the board elsewhere
    function automatic logic [7:0] exp_level(input logic [7:0] e, input logic [7:0] lt);
        return (e & ((alt_drive & alt_out) | (~alt_drive & lt))) | (~e & ext_val);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // One classic cycle; only the watchdog ends a wait for ack
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(rd, {24'h0, exp});
    endtask

    task automatic pulse_fetch();
        @(posedge clk);
        fetch <= 1'b1;
        @(posedge clk);
        fetch <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic final_report();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog far beyond the expected run of about a thousand cycles
    initial begin
        #400000;
        n_fail++;
        final_report();
    end

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        check(32'(poe), 32'h0);
        check(32'(pull), 32'h0);
        read_check(OFFSET_DIRECTION, RESET_DIRECTION);
        read_check(OFFSET_OPTION, RESET_OPTION);
        read_check(OFFSET_DATA, 8'h5a);
        bus(1'b1, 8'h40, 8'hff);
        read_check(8'h40, 8'h00);
        // Random pin setups, latch written before direction
        for (int i = 0; i < 40; i++) begin
            l = rnd();
            dir = rnd();
            opt = rnd();
            if (i == 0) begin
                {l, dir, opt} = 24'hffffff;
            end
            bus(1'b1, OFFSET_DATA, l);
            bus(1'b1, OFFSET_DIRECTION, dir);
            bus(1'b1, OFFSET_OPTION, opt);
            ext_val <= (i == 0) ? 8'h00 : rnd();
            alt_drive <= (i < 20) ? 8'h00 : rnd();
            alt_out <= rnd();
            alt_od <= rnd();
            alt_claim <= rnd();
            repeat (4) @(posedge clk);
            oe = exp_oe(dir, opt, l);
            lv = exp_level(oe, l);
            rv = (~dir & alt_drive & alt_out) | (~(~dir & alt_drive) & lv);
            check(32'(poe), 32'(oe));
            check(32'(pout & poe), 32'(oe & exp_level(8'hff, l)));
            check(32'(alt_in), 32'((dir & l) | (~dir & lv)));
            check(32'(pull), 32'(~dir & ~alt_drive & opt));
            read_check(OFFSET_DATA, rv);
            read_check(OFFSET_DIRECTION, dir);
            read_check(OFFSET_OPTION, opt);
        end
        // Interrupt on pin 0 only, no peripheral claims
        alt_drive <= 8'h00;
        alt_claim <= 8'h00;
        ext_val <= 8'hff;
        bus(1'b1, OFFSET_DIRECTION, 8'h00);
        bus(1'b1, OFFSET_SENSITIVITY, SENS_RISE);
        bus(1'b1, OFFSET_OPTION, 8'h01);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, OFFSET_SENSITIVITY, 8'(m));
            ext_val <= 8'hfe;
            repeat (4) @(posedge clk);
            check(32'(irq), 32'(m != 1));
            pulse_fetch();
            check(32'(irq), 32'(m == 0));
            ext_val <= 8'hff;
            repeat (4) @(posedge clk);
            check(32'(irq), 32'(m != 2));
            pulse_fetch();
            check(32'(irq), 32'h0);
        end
        // A low pin masks the others, then disabling it looks like a rise
        bus(1'b1, OFFSET_SENSITIVITY, SENS_FALL);
        bus(1'b1, OFFSET_OPTION, 8'h03);
        ext_val <= 8'hfd;
        repeat (4) @(posedge clk);
        check(32'(irq), 32'h1);
        pulse_fetch();
        ext_val <= 8'hfc;
        repeat (4) @(posedge clk);
        check(32'(irq), 32'h0);
        ext_val <= 8'hfd;
        bus(1'b1, OFFSET_SENSITIVITY, SENS_RISE);
        bus(1'b1, OFFSET_OPTION, 8'h01);
        repeat (4) @(posedge clk);
        check(32'(irq), 32'h1);
        // Undriven inputs with the option set are held high by the pull-ups
        ext_en <= 8'h00;
        bus(1'b1, OFFSET_OPTION, 8'hff);
        repeat (4) @(posedge clk);
        check(32'(pull), 32'hff);
        read_check(OFFSET_DATA, 8'hff);
        // Floating inputs hand the pin level to a receiving peripheral
        ext_en <= 8'hff;
        ext_val <= 8'h3c;
        bus(1'b1, OFFSET_OPTION, 8'h00);
        alt_claim <= 8'hff;
        repeat (4) @(posedge clk);
        check(32'(alt_in), 32'h3c);
        read_check(OFFSET_DATA, 8'h3c);
        // A write with the low byte lane off is acked but dropped
        sel <= 4'he;
        bus(1'b1, OFFSET_DIRECTION, 8'hff);
        sel <= 4'hf;
        read_check(OFFSET_DIRECTION, 8'h00);
        // Reset in mid-run clears a live configuration
        bus(1'b1, OFFSET_DATA, 8'h0f);
        bus(1'b1, OFFSET_DIRECTION, 8'h0f);
        bus(1'b1, OFFSET_OPTION, 8'hf0);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        check(32'({poe, pull}), 32'h0);
        check(32'(irq), 32'h0);
        read_check(OFFSET_DIRECTION, RESET_DIRECTION);
        read_check(OFFSET_OPTION, RESET_OPTION);
        final_report();
    end
endmodule
